// ==== hw/stic_pkg.sv ====
// package for the s/t interface command decoder: command codes, modes, carriers
// assumes one 20 mhz clock domain; commands arrive already deserialised
`default_nettype none
package stic_pkg;
  // command codes on the decoded command port (8 bits, arbitrary encoding)
  localparam logic [7:0] CMD_POWER_ON     = 8'h0_1;
  localparam logic [7:0] CMD_POWER_OFF    = 8'h0_2;
  localparam logic [7:0] CMD_ACT_REQ      = 8'h0_3;
  localparam logic [7:0] CMD_DEACT_REQ    = 8'h0_4;
  localparam logic [7:0] CMD_FORCE_INFO2  = 8'h0_5;
  localparam logic [7:0] CMD_LINE_MONITOR = 8'h0_6;
  localparam logic [7:0] CMD_NT_ADAPTIVE  = 8'h1_0;
  localparam logic [7:0] CMD_NT_FIXED     = 8'h1_1;
  localparam logic [7:0] CMD_TE_MASTER    = 8'h1_2;
  localparam logic [7:0] CMD_TE_SLAVE     = 8'h1_3;
  localparam logic [7:0] CMD_FORMAT_BASE  = 8'h2_0; // 0x20..0x23 = format one..four
  localparam logic [7:0] CMD_RATE_BASE    = 8'h2_4; // 0x24..0x27 = rate one..four
  localparam logic [7:0] CMD_B_STRAIGHT   = 8'h3_0;
  localparam logic [7:0] CMD_B_SWAP       = 8'h3_1;
  localparam logic [7:0] CMD_B1_ON        = 8'h3_2;
  localparam logic [7:0] CMD_B1_OFF       = 8'h3_3;
  localparam logic [7:0] CMD_B2_ON        = 8'h3_4;
  localparam logic [7:0] CMD_B2_OFF       = 8'h3_5;
  localparam logic [7:0] CMD_B1_INVERT    = 8'h3_6;
  localparam logic [7:0] CMD_B2_INVERT    = 8'h3_7;
  localparam logic [7:0] CMD_B_NORMAL     = 8'h3_8;

  // device mode codes
  typedef enum logic [1:0] {
    STIC_MODE_NT_ADAPTIVE = 2'b00,
    STIC_MODE_NT_FIXED    = 2'b01,
    STIC_MODE_TE_MASTER   = 2'b10,
    STIC_MODE_TE_SLAVE    = 2'b11
  } stic_mode_t;

  // activation sequencer states
  typedef enum logic [2:0] {
    STIC_ST_POWERED_DOWN = 3'b000,
    STIC_ST_DEACTIVATED  = 3'b001,
    STIC_ST_ACTIVATING   = 3'b010,
    STIC_ST_ACTIVE       = 3'b011,
    STIC_ST_FORCED_INFO2 = 3'b100,
    STIC_ST_DEACTIVATING = 3'b101
  } stic_state_t;

  // line signal being sent
  typedef enum logic [2:0] {
    STIC_INFO_0 = 3'b000,
    STIC_INFO_1 = 3'b001,
    STIC_INFO_2 = 3'b010,
    STIC_INFO_3 = 3'b011,
    STIC_INFO_4 = 3'b100
  } stic_info_t;

  // b channel configuration carrier
  typedef struct packed {
    logic swap;        // b1/b2 exchanged
    logic b1_on;       // system-side slot b1 enabled
    logic b2_on;       // system-side slot b2 enabled
    logic b1_invert;   // invert transmitted b1
    logic b2_invert;   // invert transmitted b2
  } stic_bcfg_t;

  // interface timing carrier
  typedef struct packed {
    logic [1:0] format;    // format one..four as 0..3
    logic [1:0] bit_rate;  // rate one..four as 0..3
  } stic_dif_t;

  // reset values
  localparam stic_mode_t  RST_MODE  = STIC_MODE_NT_ADAPTIVE;
  localparam stic_bcfg_t  RST_BCFG  = 5'b0_0000;
  localparam stic_dif_t   RST_DIF   = 4'h0;
  localparam logic [1:0]  FMT_ONE   = 2'h0;

  // deactivation run-down before info 0 settles (one frame of 250 us)
  localparam int DEACT_TIME_US = 250;
  localparam int CLK_MHZ       = 20;
  localparam logic [12:0] DEACT_CYCLES = 13'(DEACT_TIME_US * CLK_MHZ);
endpackage
`default_nettype wire

// ==== hw/stic_bpath.sv ====
// b channel data path: swap, enable and polarity for one bit slot
// assumes slot strobes from the framing logic on the same clock
`default_nettype none
module stic_bpath
  import stic_pkg::*;
(
  input  wire logic       clk,          // system clock
  input  wire logic       arst_n,       // async reset, active low
  input  wire stic_bcfg_t bcfg,         // b channel settings
  input  wire logic       slot_b1,      // current bit is a system-side b1 slot
  input  wire logic       slot_b2,      // current bit is a system-side b2 slot
  input  wire logic       b_transmit_in,// system transmit data bit
  input  wire logic       line_rx_bit,  // line receive data bit for this slot
  output logic            line_tx_bit,  // bit sent to the line
  output logic            b_receive_out,// system receive data
  output logic            b_receive_oe  // receive output driven
);
  // ****************************************
  // slot gating
  // ****************************************
  logic line_is_b1; // line slot carrying this system slot
  logic en_slot;    // enable of system-side slot
  logic inv_slot;   // polarity of line slot
  logic any_slot;   // inside either b slot

  // enables follow the system slot even when swapped
  always_comb begin
    any_slot   = slot_b1 | slot_b2;
    en_slot    = slot_b1 ? bcfg.b1_on : bcfg.b2_on;
    line_is_b1 = slot_b1 ^ bcfg.swap;
    inv_slot   = line_is_b1 ? bcfg.b1_invert : bcfg.b2_invert;
  end

  // registered outputs: disabled slots send ones and float receive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_tx_bit   <= 1'b1;
      b_receive_out <= 1'b0;
      b_receive_oe  <= 1'b0;
    end else begin
      if (any_slot && en_slot) begin
        line_tx_bit   <= b_transmit_in ^ inv_slot;
        b_receive_out <= line_rx_bit;
        b_receive_oe  <= 1'b1;
      end else begin
        line_tx_bit   <= 1'b1;
        b_receive_out <= 1'b0;
        b_receive_oe  <= 1'b0;
      end
    end
  end
endmodule // stic_bpath
`default_nettype wire

// ==== hw/stic_ctrl.sv ====
// control command interpreter of the s/t transceiver
// assumes cmd_valid/cmd_code come from the serial port logic on clk;
// line status inputs come from the receiver and are synchronised here
`default_nettype none
// Function
// - power-on enables analog, oscillator, deactivates, info 0
// - power-on masks signal detect, power-off enables
// - power-off goes low power immediately
// - deactivation request runs deactivation sequence
// - force info two only active network modes
// - forced: pending flag, keep sync, block data
// - line monitor activates on info 3 as master
// - network adaptive: adaptive sampling, slave clocks
// - network fixed: dpll off, fixed sampling, slave
// - terminal master: generate clocks, d access on
// - terminal slave: buffered resync, slave clock out
// - terminal slave: d access off, requests ignored
// - format command sets matching default rate
// - rate command changes current format's rate
// - straight or swapped b channel path
// - disabled b slots send ones, float receive
// - per-channel invert, normal restores both
// - enables refer to system-side slots
module stic_ctrl
  import stic_pkg::*;
#(
  parameter logic [12:0] DEACT_LEN = DEACT_CYCLES // deactivation run-down in cycles
) (
  input  wire logic       clk,                  // 20 mhz clock
  input  wire logic       arst_n,               // async reset, active low
  input  wire logic       cmd_valid,            // one-cycle command strobe
  input  wire logic [7:0] cmd_code,             // command byte
  input  wire logic       rx_info3_pin,         // receiver sees info 3 (async)
  input  wire logic       rx_info1_pin,         // receiver sees info 1 (async)
  input  wire logic       rx_info24_pin,        // receiver sees info 2 or 4 (async)
  input  wire logic       line_energy_pin,      // raw line energy (async)
  input  wire logic       d_channel_request,    // layer 2 wants the d channel
  input  wire logic       slot_b1,              // system-side b1 slot
  input  wire logic       slot_b2,              // system-side b2 slot
  input  wire logic       b_transmit_in,        // system transmit data
  input  wire logic       line_rx_bit,          // line receive b bit
  output logic            line_tx_bit,          // line transmit b bit
  output logic            b_receive_out,        // system receive data
  output logic            b_receive_oe,         // receive output drive enable
  output logic            analog_on,            // analog circuits powered
  output logic            osc_on,               // crystal oscillator running
  output logic            line_signal_detect,   // wake-up output
  output stic_info_t      tx_info,              // line signal being sent
  output stic_state_t     act_state,            // activation state
  output logic            activation_pending,   // pending flag pulse
  output logic            data_blocked,         // 2b+d transfer inhibited
  output logic            loop_sync,            // loop synchronised
  output logic            clocks_master,        // drive bit clock and frame_sync
  output logic            adaptive_sampling,    // adaptive receive sampling
  output logic            dpll_on,              // receive dpll running
  output logic            resync_on,            // slave buffers and resync active
  output logic            slave_clock_out,      // slave clock at d gate pin
  output logic            d_access_on,          // d priority/contention active
  output logic            d_request_taken,      // d request accepted
  output logic            monitor_on,           // line monitor mode
  output stic_dif_t       dif                   // format and bit rate
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [3:0] sync1_reg; // first stage, read only by the second
  logic [3:0] sync2_reg; // usable stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {line_energy_pin, rx_info24_pin, rx_info1_pin, rx_info3_pin};
      sync2_reg <= sync1_reg;
    end
  end
  logic rx_info3, rx_info1, rx_info24, line_energy;
  assign rx_info3    = sync2_reg[0];
  assign rx_info1    = sync2_reg[1];
  assign rx_info24   = sync2_reg[2];
  assign line_energy = sync2_reg[3];

  // ****************************************
  // command decode helpers
  // ****************************************
  // true when the strobe carries the given code
  function automatic logic is_cmd(input logic v, input logic [7:0] c, input logic [7:0] k);
    return v && (c == k);
  endfunction
  // true when code falls in a group of four starting at base
  function automatic logic in_quad(input logic v, input logic [7:0] c, input logic [7:0] b);
    return v && (c[7:2] == b[7:2]);
  endfunction

  logic c_pon, c_poff, c_ar, c_dr, c_fi2, c_mon;
  assign c_pon  = is_cmd(cmd_valid, cmd_code, CMD_POWER_ON);
  assign c_poff = is_cmd(cmd_valid, cmd_code, CMD_POWER_OFF);
  assign c_ar   = is_cmd(cmd_valid, cmd_code, CMD_ACT_REQ);
  assign c_dr   = is_cmd(cmd_valid, cmd_code, CMD_DEACT_REQ);
  assign c_fi2  = is_cmd(cmd_valid, cmd_code, CMD_FORCE_INFO2);
  assign c_mon  = is_cmd(cmd_valid, cmd_code, CMD_LINE_MONITOR);

  // ****************************************
  // power control
  // ****************************************
  logic power_reg; // analog and oscillator enabled
  logic lsd_en_reg; // signal detect circuit enabled
  // power-off wins nothing over power-on in the same strobe: one code per strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_reg  <= 1'b0;
      lsd_en_reg <= 1'b1;
    end else if (c_pon) begin
      power_reg  <= 1'b1;
      lsd_en_reg <= 1'b0;
    end else if (c_poff) begin
      power_reg  <= 1'b0;
      lsd_en_reg <= 1'b1;
    end
  end
  assign analog_on = power_reg;
  assign osc_on    = power_reg;
  // detect output is a registered copy of gated line energy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) line_signal_detect <= 1'b0;
    else         line_signal_detect <= lsd_en_reg & line_energy;
  end

  // ****************************************
  // device mode and line monitor
  // ****************************************
  stic_mode_t mode_reg; // current device mode
  logic       mon_reg;  // line monitor selected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= RST_MODE;
    end else if (cmd_valid) begin
      case (cmd_code)
        CMD_NT_ADAPTIVE: mode_reg <= STIC_MODE_NT_ADAPTIVE;
        CMD_NT_FIXED:    mode_reg <= STIC_MODE_NT_FIXED;
        CMD_TE_MASTER:   mode_reg <= STIC_MODE_TE_MASTER;
        CMD_TE_SLAVE:    mode_reg <= STIC_MODE_TE_SLAVE;
        default:         mode_reg <= mode_reg;
      endcase
    end
  end
  // monitor only meaningful from terminal master; another mode command clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mon_reg <= 1'b0;
    else if (c_mon) mon_reg <= (mode_reg == STIC_MODE_TE_MASTER);
    else if (in_quad(cmd_valid, cmd_code, CMD_NT_ADAPTIVE)) mon_reg <= 1'b0;
  end
  logic is_nt;
  assign is_nt = (mode_reg == STIC_MODE_NT_ADAPTIVE) || (mode_reg == STIC_MODE_NT_FIXED);
  assign monitor_on        = mon_reg;
  assign adaptive_sampling = (mode_reg != STIC_MODE_NT_FIXED);
  assign dpll_on           = (mode_reg != STIC_MODE_NT_FIXED);
  assign clocks_master     = (mode_reg == STIC_MODE_TE_MASTER);
  assign resync_on         = (mode_reg == STIC_MODE_TE_SLAVE);
  assign slave_clock_out   = (mode_reg == STIC_MODE_TE_SLAVE);
  assign d_access_on       = (mode_reg == STIC_MODE_TE_MASTER);
  assign d_request_taken   = d_channel_request & d_access_on;

  // ****************************************
  // interface format and bit rate
  // ****************************************
  stic_dif_t dif_reg; // format and rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dif_reg <= RST_DIF;
    end else if (in_quad(cmd_valid, cmd_code, CMD_FORMAT_BASE)) begin
      dif_reg.format   <= cmd_code[1:0];
      dif_reg.bit_rate <= cmd_code[1:0];
    end else if (in_quad(cmd_valid, cmd_code, CMD_RATE_BASE)) begin
      dif_reg.bit_rate <= cmd_code[1:0];
    end
  end
  assign dif = dif_reg;

  // ****************************************
  // b channel settings
  // ****************************************
  stic_bcfg_t bcfg_reg; // b path settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bcfg_reg <= RST_BCFG;
    end else if (cmd_valid) begin
      case (cmd_code)
        CMD_B_STRAIGHT: bcfg_reg.swap  <= 1'b0;
        CMD_B_SWAP:     bcfg_reg.swap  <= 1'b1;
        CMD_B1_ON:      bcfg_reg.b1_on <= 1'b1;
        CMD_B1_OFF:     bcfg_reg.b1_on <= 1'b0;
        CMD_B2_ON:      bcfg_reg.b2_on <= 1'b1;
        CMD_B2_OFF:     bcfg_reg.b2_on <= 1'b0;
        CMD_B1_INVERT:  bcfg_reg.b1_invert <= 1'b1;
        CMD_B2_INVERT:  bcfg_reg.b2_invert <= 1'b1;
        CMD_B_NORMAL: begin
          bcfg_reg.b1_invert <= 1'b0;
          bcfg_reg.b2_invert <= 1'b0;
        end
        default:        bcfg_reg <= bcfg_reg;
      endcase
    end
  end

  // data path; blocked transfer forces all slots off like disabled channels
  stic_bcfg_t bcfg_eff;
  always_comb begin
    bcfg_eff = bcfg_reg;
    if (data_blocked) begin
      bcfg_eff.b1_on = 1'b0;
      bcfg_eff.b2_on = 1'b0;
    end
  end
  stic_bpath u_bpath (
    .clk           (clk),
    .arst_n        (arst_n),
    .bcfg          (bcfg_eff),
    .slot_b1       (slot_b1),
    .slot_b2       (slot_b2),
    .b_transmit_in (b_transmit_in),
    .line_rx_bit   (line_rx_bit),
    .line_tx_bit   (line_tx_bit),
    .b_receive_out (b_receive_out),
    .b_receive_oe  (b_receive_oe)
  );

  // ****************************************
  // activation sequencer
  // ****************************************
  stic_state_t st_reg;  // current state
  logic [12:0] deact_cnt_reg; // run-down counter
  logic        rx_wake;  // far end signal that completes activation
  // network ends finish on info 3; terminals on info 2/4; monitor on info 3
  assign rx_wake = (is_nt || mon_reg) ? rx_info3 : rx_info24;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= STIC_ST_POWERED_DOWN;
    end else if (c_poff) begin
      st_reg <= STIC_ST_POWERED_DOWN;
    end else if (c_pon) begin
      st_reg <= STIC_ST_DEACTIVATED;
    end else begin
      case (st_reg)
        STIC_ST_POWERED_DOWN: st_reg <= STIC_ST_POWERED_DOWN;
        STIC_ST_DEACTIVATED:  if (c_ar) st_reg <= STIC_ST_ACTIVATING;
        STIC_ST_ACTIVATING: begin
          if (c_dr)         st_reg <= STIC_ST_DEACTIVATING;
          else if (rx_wake) st_reg <= STIC_ST_ACTIVE;
        end
        STIC_ST_ACTIVE: begin
          if (c_dr)                st_reg <= STIC_ST_DEACTIVATING;
          else if (c_fi2 && is_nt) st_reg <= STIC_ST_FORCED_INFO2;
        end
        STIC_ST_FORCED_INFO2: begin
          if (c_dr)      st_reg <= STIC_ST_DEACTIVATING;
          else if (c_ar) st_reg <= STIC_ST_ACTIVE;
        end
        STIC_ST_DEACTIVATING: if (deact_cnt_reg == 13'h0_000) st_reg <= STIC_ST_DEACTIVATED;
        default: st_reg <= STIC_ST_POWERED_DOWN;
      endcase
    end
  end
  // run-down timer loads on entering deactivation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) deact_cnt_reg <= 13'h0_000;
    else if (c_dr) deact_cnt_reg <= DEACT_LEN - 13'h0_001;
    else if (deact_cnt_reg != 13'h0_000) deact_cnt_reg <= deact_cnt_reg - 13'h0_001;
  end
  assign act_state = st_reg;

  // line signal per state; info 0 whenever down or deactivated
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tx_info <= STIC_INFO_0;
    else begin
      case (st_reg)
        STIC_ST_ACTIVATING:   tx_info <= mon_reg ? STIC_INFO_0 : (is_nt ? STIC_INFO_2 : STIC_INFO_3);
        STIC_ST_ACTIVE:       tx_info <= mon_reg ? STIC_INFO_0 : (is_nt ? STIC_INFO_4 : STIC_INFO_3);
        STIC_ST_FORCED_INFO2: tx_info <= STIC_INFO_2;
        default:              tx_info <= STIC_INFO_0;
      endcase
    end
  end

  // pending pulse when forced and info 3 first seen, or ordinary wake signals
  logic pend_arm_reg; // at most one pulse until active or powered down re-arms it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_arm_reg       <= 1'b0;
      activation_pending <= 1'b0;
    end else begin
      activation_pending <= 1'b0;
      if (st_reg == STIC_ST_FORCED_INFO2 && rx_info3 && !pend_arm_reg) begin
        activation_pending <= 1'b1;
        pend_arm_reg       <= 1'b1;
      end else if (st_reg == STIC_ST_DEACTIVATED && (is_nt ? rx_info1 : rx_info24) && !pend_arm_reg) begin
        activation_pending <= 1'b1;
        pend_arm_reg       <= 1'b1;
      end else if (st_reg == STIC_ST_ACTIVE || st_reg == STIC_ST_POWERED_DOWN) begin
        pend_arm_reg <= 1'b0;
      end
    end
  end
  assign loop_sync    = (st_reg == STIC_ST_ACTIVE) || (st_reg == STIC_ST_FORCED_INFO2 && rx_info3);
  assign data_blocked = (st_reg != STIC_ST_ACTIVE);

  // ****************************************
  // checks
  // ****************************************
  pwr_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    c_pon |=> (power_reg && st_reg == STIC_ST_DEACTIVATED) ##1 tx_info == STIC_INFO_0)
    else $error("power on did not reset to deactivated");
  lsd_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    c_pon |=> ##1 !line_signal_detect) else $error("detect not masked");
  pwr_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    c_poff |=> st_reg == STIC_ST_POWERED_DOWN && !analog_on) else $error("power off late");
  deact_a: assert property (@(posedge clk) disable iff (!arst_n)
    (c_dr && st_reg == STIC_ST_ACTIVE && !c_poff && !c_pon) |=> st_reg == STIC_ST_DEACTIVATING)
    else $error("deactivation not started");
  // forced info 2 is entered only from an active network end; a later mode change is not a fault
  fi2_nt_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg != STIC_ST_FORCED_INFO2 && !(c_fi2 && is_nt && st_reg == STIC_ST_ACTIVE))
      |=> st_reg != STIC_ST_FORCED_INFO2) else $error("forced info 2 outside network mode");
  // the b path itself must show the block: ones on the line, receive floated
  fi2_blk_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg == STIC_ST_FORCED_INFO2) |=> !b_receive_oe && line_tx_bit) else $error("data not blocked");
  fmt_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    in_quad(cmd_valid, cmd_code, CMD_FORMAT_BASE) |=> dif.format == $past(cmd_code[1:0]) && dif.bit_rate == dif.format)
    else $error("format default rate wrong");
  rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    in_quad(cmd_valid, cmd_code, CMD_RATE_BASE) |=> dif.bit_rate == $past(cmd_code[1:0]))
    else $error("rate not applied");
  slave_d_a: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_reg == STIC_MODE_TE_SLAVE) |-> !d_request_taken) else $error("slave took d request");
  fixed_a: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_reg == STIC_MODE_NT_FIXED) |-> !dpll_on && !clocks_master) else $error("fixed mode wrong");
  act_c: cover property (@(posedge clk) disable iff (!arst_n) st_reg == STIC_ST_ACTIVE);
  fi2_c: cover property (@(posedge clk) disable iff (!arst_n) activation_pending && st_reg == STIC_ST_FORCED_INFO2);
  deact_c: cover property (@(posedge clk) disable iff (!arst_n)
    st_reg == STIC_ST_DEACTIVATING ##1 st_reg == STIC_ST_DEACTIVATED);
endmodule // stic_ctrl
`default_nettype wire

// ==== testbench/stic_far_end.sv ====
// remote terminal model on the line side of the decoder
// assumes the line signal being sent is seen as tx_info
`default_nettype none
module stic_far_end
  import stic_pkg::*;
#(
  parameter int DELAY = 3 // info 3 answers once info 2 or 4 has been heard for more than this many cycles
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire stic_info_t tx_info,
  output logic            rx_info3_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // cycles that info 2 or 4 has been heard
  // keeps answering while forced back to info 2, drops on info 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt <= 0;
    else if (tx_info == STIC_INFO_2 || tx_info == STIC_INFO_4) cnt <= cnt + 1;
    else cnt <= 0;
  end
  assign rx_info3_pin = (cnt > DELAY);
endmodule // stic_far_end
`default_nettype wire

// ==== testbench/stic_ctrl_tb.sv ====
// self-checking bench for the control command decoder
// assumes one 20 mhz clock; inputs change on the falling edge
`default_nettype none
module stic_ctrl_tb
  import stic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, cmd_valid, d_channel_request, slot_b1, b_transmit_in, line_energy_pin, ap_seen;
  logic line_tx_bit, b_receive_out, b_receive_oe, analog_on, osc_on, line_signal_detect, activation_pending;
  logic data_blocked, loop_sync, clocks_master, adaptive_sampling, dpll_on, resync_on, slave_clock_out;
  logic d_access_on, d_request_taken, monitor_on, line_rx_bit;
  logic [7:0] cmd_code;
  wire logic rx_info3_pin;
  stic_info_t tx_info;
  stic_state_t act_state;
  stic_dif_t dif;
  int n_errors, n_checks, cyc;
  stic_far_end i_far (.clk, .arst_n, .tx_info, .rx_info3_pin);
  stic_ctrl #(.DEACT_LEN(13'h0004)) i_dut (.clk, .arst_n, .cmd_valid, .cmd_code, .rx_info3_pin,
    .rx_info1_pin(1'b0), .rx_info24_pin(1'b0), .line_energy_pin, .d_channel_request, .slot_b1, .slot_b2(1'b0),
    .b_transmit_in, .line_rx_bit, .line_tx_bit, .b_receive_out, .b_receive_oe, .analog_on, .osc_on,
    .line_signal_detect, .tx_info, .act_state, .activation_pending, .data_blocked, .loop_sync, .clocks_master,
    .adaptive_sampling, .dpll_on, .resync_on, .slave_clock_out, .d_access_on, .d_request_taken, .monitor_on, .dif);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobe, entered and left at a falling edge; an idle edge follows
  // so that a second call never raises the strobe in the step that lowered it
  task automatic cmd(input logic [7:0] c);
    cmd_code = c;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_st(input stic_state_t s);
    for (int i = 0; i < 20 && act_state !== s; i++) @(negedge clk);
    chk(act_state, s);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pending flag is a one-cycle pulse, so latch it; hang guard beside it
  always @(posedge clk) begin
    cyc++;
    if (activation_pending === 1'b1) ap_seen = 1'b1;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {arst_n, cmd_valid, slot_b1, b_transmit_in, ap_seen} = '0;
    {d_channel_request, line_energy_pin, line_rx_bit} = 3'h7;
    cmd_code = 8'h00;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({line_signal_detect, dif}, 5'h10);
    cmd(CMD_POWER_ON);
    chk({analog_on, osc_on, act_state}, {2'h3, STIC_ST_DEACTIVATED});
    @(negedge clk);
    chk({tx_info, line_signal_detect}, {STIC_INFO_0, 1'b0});
    repeat (40000) @(negedge clk);
    $display("test power done");
    for (int n = 0; n < 4; n++) begin
      cmd(CMD_FORMAT_BASE + 8'(n));
      chk(dif, {n[1:0], n[1:0]});
    end
    cmd(CMD_RATE_BASE + 8'h01);
    chk(dif, 4'hd);
    cmd(CMD_FORMAT_BASE + 8'h02);
    chk(dif, 4'ha);
    cmd(CMD_TE_MASTER);
    chk({clocks_master, d_access_on, d_request_taken}, 3'h7);
    cmd(CMD_LINE_MONITOR);
    chk(monitor_on, 1'b1);
    cmd(CMD_TE_SLAVE);
    chk({clocks_master, resync_on, slave_clock_out, d_access_on, d_request_taken, monitor_on}, 6'h18);
    cmd(CMD_LINE_MONITOR);
    chk(monitor_on, 1'b0);
    cmd(CMD_NT_FIXED);
    chk({dpll_on, adaptive_sampling, clocks_master}, 3'h0);
    cmd(CMD_FORCE_INFO2);
    chk(act_state, STIC_ST_DEACTIVATED);
    cmd(CMD_NT_ADAPTIVE);
    chk({dpll_on, adaptive_sampling, clocks_master}, 3'h6);
    $display("test modes done");
    cmd(CMD_ACT_REQ);
    chk({act_state, tx_info}, {STIC_ST_ACTIVATING, STIC_INFO_2});
    wait_st(STIC_ST_ACTIVE);
    cmd(CMD_B1_ON);
    slot_b1 = 1'b1;
    repeat (2) @(negedge clk);
    chk({line_tx_bit, b_receive_oe, b_receive_out, tx_info}, {3'h3, STIC_INFO_4});
    cmd(CMD_B1_INVERT);
    repeat (2) @(negedge clk);
    chk(line_tx_bit, 1'b1);
    cmd(CMD_B_NORMAL);
    repeat (2) @(negedge clk);
    chk(line_tx_bit, 1'b0);
    cmd(CMD_B1_OFF);
    repeat (2) @(negedge clk);
    chk({line_tx_bit, b_receive_oe, b_receive_out}, 3'h4);
    cmd(CMD_B_SWAP);
    cmd(CMD_B2_INVERT);
    cmd(CMD_B1_ON);
    repeat (2) @(negedge clk);
    chk({line_tx_bit, b_receive_oe}, 2'h3);
    cmd(CMD_B_STRAIGHT);
    repeat (2) @(negedge clk);
    chk({line_tx_bit, b_receive_oe}, 2'h1);
    ap_seen = 1'b0;
    cmd(CMD_FORCE_INFO2);
    chk(act_state, STIC_ST_FORCED_INFO2);
    repeat (4) @(negedge clk);
    chk({tx_info, data_blocked, loop_sync, ap_seen}, {STIC_INFO_2, 3'h7});
    cmd(CMD_ACT_REQ);
    chk(act_state, STIC_ST_ACTIVE);
    cmd(CMD_DEACT_REQ);
    chk(act_state, STIC_ST_DEACTIVATING);
    wait_st(STIC_ST_DEACTIVATED);
    cmd(CMD_POWER_OFF);
    chk({analog_on, act_state}, {1'b0, STIC_ST_POWERED_DOWN});
    repeat (2) @(negedge clk);
    chk(line_signal_detect, 1'b1);
    $display("test activation done");
    conclude();
  end
endmodule // stic_ctrl_tb
`default_nettype wire
